// [include/rsl_pkg.sv]
// Shared constants for the reclose shot / initiate / lockout core
package rsl_pkg;
   // Widths
   localparam int SHOT_W = 3; // Shot counter width
   localparam int OI_W = 16; // Open-interval setting width
   localparam int TICK_W = 17; // Timebase prescaler width
   localparam int DROP_W = 10; // Dropout tick counter width
   // Shot values
   localparam logic [SHOT_W-1:0] SHOT_ZERO = 3'h0; // First shot
   localparam logic [SHOT_W-1:0] SHOT_ONE = 3'h1; // Increment step
   localparam logic [SHOT_W-1:0] SHOT_MAX = 3'h4; // Highest shot, no interval
   localparam logic [OI_W-1:0] OI_NONE = 16'h0000; // Interval set to zero
   // Timebase
   localparam int CLK_PERIOD_NS = 10; // 100 MHz processing clock
   localparam int TICK_PERIOD_NS = 1000000; // 1 ms timebase
   localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS; // Cycles per tick
   // Drive-to-lockout dropout
   localparam int DROPOUT_S = 1; // Dropout time in seconds
   localparam int TICKS_PER_S = 1000; // Ticks in one second
   localparam logic [DROP_W-1:0] DROPOUT_TICKS = DROP_W'(DROPOUT_S * TICKS_PER_S); // Reload value
   localparam logic [DROP_W-1:0] DROP_ZERO = 10'h000; // Stretch expired
   localparam logic [DROP_W-1:0] DROP_ONE = 10'h001; // Decrement step
   // Reclosing states
   typedef enum logic [1:0] {
      RSL_RESET,
      RSL_CYCLE,
      RSL_LOCKOUT
   } rsl_state_e;
endpackage

// [core/rsl_core.sv]
// Notes on behaviour
// R1: Shot zero first; advance on interval expiry
// R2: Automatic advance saturates at last shot
// R3: Entering Reset clears shot counter
// R4: Shot selects interval one to four
// R5: One flag per shot, only current set
// R6: Sequence coordination advances past last shot
// R7: Initiate acts on rising edge only
// R8: Edge with supervision below last shot starts interval timing
// R9: Edge without supervision goes to Lockout
// R10: Trip with breaker open mid-interval locks out
// R11: Drive-to-lockout forces Lockout, flag, indicator
// R12: Drive-to-lockout held one second after drop
// R13: Drive-to-last-shot loads last shot if below
// R14: Last shot counts nonzero intervals before zero
// R15: Three states; cycle flag only in cycle
// R16: Stretch is tick-driven reloadable down-counter
`timescale 1ns/1ns
module rsl_core #(
   parameter int TICK_CYCLES = rsl_pkg::TICK_CYCLES_DEF // Shorten in simulation
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Open-interval settings
   input wire logic [rsl_pkg::OI_W-1:0] OPEN_INTERVAL_ONE_I,
   input wire logic [rsl_pkg::OI_W-1:0] OPEN_INTERVAL_TWO_I,
   input wire logic [rsl_pkg::OI_W-1:0] OPEN_INTERVAL_THREE_I,
   input wire logic [rsl_pkg::OI_W-1:0] OPEN_INTERVAL_FOUR_I,
   // Trip logic conditions
   input wire logic RECLOSE_INITIATE_COND_I,
   input wire logic RECLOSE_INITIATE_SUPERVISION_I,
   input wire logic SUPERVISION_DEFAULT_I,
   input wire logic DRIVE_TO_LOCKOUT_COND_I,
   input wire logic DRIVE_TO_LAST_SHOT_COND_I,
   input wire logic SEQUENCE_COORDINATION_COND_I,
   // Breaker status pin
   input wire logic BREAKER_CLOSED_STATUS_I,
   // Timer feedback
   input wire logic OPEN_INTERVAL_EXPIRED_I,
   input wire logic RESET_TIMER_DONE_I,
   // Shot outputs
   output logic [rsl_pkg::SHOT_W-1:0] SHOT_O,
   output logic [rsl_pkg::SHOT_W-1:0] LAST_SHOT_O,
   output logic SHOT_FLAG_ZERO_O,
   output logic SHOT_FLAG_ONE_O,
   output logic SHOT_FLAG_TWO_O,
   output logic SHOT_FLAG_THREE_O,
   output logic SHOT_FLAG_FOUR_O,
   // Timer control outputs
   output logic [rsl_pkg::OI_W-1:0] OPEN_INTERVAL_SEL_O,
   output logic START_OPEN_INTERVAL_O,
   output logic OPEN_INTERVAL_TIMING_O,
   // State outputs
   output logic RESET_STATE_O,
   output logic RECLOSE_CYCLE_FLAG_O,
   output logic LOCKOUT_FLAG_O,
   output logic LOCKOUT_INDICATOR_O
);
   import rsl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Count of nonzero intervals ahead of the first zero one
   function automatic logic [SHOT_W-1:0] last_shot_of(input logic [OI_W-1:0] a, input logic [OI_W-1:0] b,
                                                      input logic [OI_W-1:0] c, input logic [OI_W-1:0] d);
      logic [SHOT_W-1:0] n;
      n = SHOT_ZERO;
      if (a != OI_NONE) begin
         n = 3'h1;
         if (b != OI_NONE) begin
            n = 3'h2;
            if (c != OI_NONE) begin
               n = 3'h3;
               if (d != OI_NONE) begin
                  n = SHOT_MAX;
               end
            end
         end
      end
      return n; // [R14]
   endfunction

   // Interval belonging to a shot; shot four has none
   function automatic logic [OI_W-1:0] interval_of(input logic [SHOT_W-1:0] s);
      case (s)
         3'h0: interval_of = OPEN_INTERVAL_ONE_I; // [R4]
         3'h1: interval_of = OPEN_INTERVAL_TWO_I;
         3'h2: interval_of = OPEN_INTERVAL_THREE_I;
         3'h3: interval_of = OPEN_INTERVAL_FOUR_I;
         default: interval_of = OI_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Breaker status synchroniser

   logic brk_meta_ff; // First stage, read only by second
   logic brk_sync_ff; // Safe breaker level
   logic nxt_brk_meta;
   logic nxt_brk_sync;

   // Next values of the synchroniser
   always_comb begin
      nxt_brk_meta = BREAKER_CLOSED_STATUS_I;
      nxt_brk_sync = brk_meta_ff;
   end

   // Synchroniser registers
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         brk_meta_ff <= 1'b0;
         brk_sync_ff <= 1'b0;
      end else begin
         brk_meta_ff <= nxt_brk_meta;
         brk_sync_ff <= nxt_brk_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timebase and drive-to-lockout stretch

   logic [TICK_W-1:0] tick_cnt_ff; // Prescaler
   logic [DROP_W-1:0] drop_cnt_ff; // Dropout remaining, in ticks
   logic [TICK_W-1:0] nxt_tick_cnt;
   logic [DROP_W-1:0] nxt_drop_cnt;
   logic tick; // One cycle per timebase period
   logic dtl_eff; // Stretched drive-to-lockout

   // Prescaler and dropout counter next values
   always_comb begin
      tick = (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));
      nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 1'b1;
      nxt_drop_cnt = drop_cnt_ff;
      if (DRIVE_TO_LOCKOUT_COND_I) begin
         nxt_drop_cnt = DROPOUT_TICKS; // [R16]
      end else if (tick && drop_cnt_ff != DROP_ZERO) begin
         nxt_drop_cnt = drop_cnt_ff - DROP_ONE; // [R16]
      end
      // Tick granularity: dropout lasts 999 to 1000 ms
      dtl_eff = DRIVE_TO_LOCKOUT_COND_I | (drop_cnt_ff != DROP_ZERO); // [R12]
   end

   // Timebase registers
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         tick_cnt_ff <= '0;
         drop_cnt_ff <= DROP_ZERO;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         drop_cnt_ff <= nxt_drop_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reclosing state, shot counter and outputs

   rsl_state_e state_ff;
   rsl_state_e nxt_state;
   logic [SHOT_W-1:0] shot_ff;
   logic [SHOT_W-1:0] nxt_shot;
   logic ri_prev_ff; // Last initiate level, for edge detect
   logic timing_ff; // Open interval running
   logic nxt_timing;
   logic start_ff;
   logic nxt_start;
   logic [SHOT_W-1:0] last_shot; // Computed from settings
   logic ri_rise;
   logic supv; // Effective initiate supervision
   logic [4:0] flags_ff; // One-hot shot flags
   logic [4:0] nxt_flags;
   logic [OI_W-1:0] oi_sel_ff;
   logic [OI_W-1:0] nxt_oi_sel; // Interval for the next shot
   logic [SHOT_W-1:0] last_ff;
   logic [2:0] state_flags_ff; // Registered state decode: lockout, cycle, reset
   logic [2:0] nxt_state_flags;

   // State and counter next values
   always_comb begin
      last_shot = last_shot_of(OPEN_INTERVAL_ONE_I, OPEN_INTERVAL_TWO_I,
                               OPEN_INTERVAL_THREE_I, OPEN_INTERVAL_FOUR_I);
      ri_rise = RECLOSE_INITIATE_COND_I & ~ri_prev_ff; // [R7]
      // Default supervision: breaker closed or already cycling
      supv = SUPERVISION_DEFAULT_I ? (brk_sync_ff | (state_ff == RSL_CYCLE))
                                   : RECLOSE_INITIATE_SUPERVISION_I;
      nxt_state = state_ff;
      nxt_shot = shot_ff;
      nxt_timing = timing_ff;
      nxt_start = 1'b0;
      // Interval expiry advances automatically, never past last shot
      if (OPEN_INTERVAL_EXPIRED_I && timing_ff) begin
         nxt_timing = 1'b0;
         if (shot_ff < last_shot) begin
            nxt_shot = shot_ff + SHOT_ONE; // [R1] [R2]
         end
      end
      // Sequence coordination may pass the last shot
      if (SEQUENCE_COORDINATION_COND_I && shot_ff < SHOT_MAX) begin
         nxt_shot = shot_ff + SHOT_ONE; // [R6]
      end
      // Drive to last shot only raises the count
      if (DRIVE_TO_LAST_SHOT_COND_I && shot_ff < last_shot) begin
         nxt_shot = last_shot; // [R13]
      end
      // Lockout causes take priority over initiation
      if (dtl_eff) begin
         nxt_state = RSL_LOCKOUT; // [R11]
         nxt_timing = 1'b0;
      end else if (ri_rise && timing_ff && !brk_sync_ff) begin
         nxt_state = RSL_LOCKOUT; // [R10]
         nxt_timing = 1'b0;
      end else if (ri_rise) begin
         if (supv && shot_ff < last_shot) begin
            nxt_state = RSL_CYCLE; // [R8]
            nxt_timing = 1'b1;
            nxt_start = 1'b1;
         end else begin
            // No supervision, or nothing left to reclose
            nxt_state = RSL_LOCKOUT; // [R9]
            nxt_timing = 1'b0;
         end
      end else if (RESET_TIMER_DONE_I && state_ff != RSL_RESET) begin
         nxt_state = RSL_RESET;
      end
      if (nxt_state == RSL_RESET && state_ff != RSL_RESET) begin
         nxt_shot = SHOT_ZERO; // [R3]
         nxt_timing = 1'b0;
      end
      nxt_flags = 5'h01 << nxt_shot; // [R5]
      nxt_oi_sel = interval_of(nxt_shot); // [R4]
      // Decode ahead of the flop so the state ports come straight from registers
      nxt_state_flags = {nxt_state == RSL_LOCKOUT, nxt_state == RSL_CYCLE, nxt_state == RSL_RESET}; // [R15]
   end

   // State registers; outputs follow the registered values
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         state_ff <= RSL_RESET;
         shot_ff <= SHOT_ZERO;
         ri_prev_ff <= 1'b0;
         timing_ff <= 1'b0;
         start_ff <= 1'b0;
         flags_ff <= 5'h01;
         oi_sel_ff <= OI_NONE;
         last_ff <= SHOT_ZERO;
         state_flags_ff <= 3'h1;
      end else begin
         state_ff <= nxt_state; // [R15]
         shot_ff <= nxt_shot;
         ri_prev_ff <= RECLOSE_INITIATE_COND_I;
         timing_ff <= nxt_timing;
         start_ff <= nxt_start;
         flags_ff <= nxt_flags;
         oi_sel_ff <= nxt_oi_sel;
         last_ff <= last_shot;
         state_flags_ff <= nxt_state_flags;
      end
   end

   // Port drive, all from flip-flops
   assign SHOT_O = shot_ff;
   assign LAST_SHOT_O = last_ff;
   assign {SHOT_FLAG_FOUR_O, SHOT_FLAG_THREE_O, SHOT_FLAG_TWO_O, SHOT_FLAG_ONE_O, SHOT_FLAG_ZERO_O} = flags_ff;
   assign OPEN_INTERVAL_SEL_O = oi_sel_ff;
   assign START_OPEN_INTERVAL_O = start_ff;
   assign OPEN_INTERVAL_TIMING_O = timing_ff;
   assign RESET_STATE_O = state_flags_ff[0];
   assign RECLOSE_CYCLE_FLAG_O = state_flags_ff[1]; // [R15]
   assign LOCKOUT_FLAG_O = state_flags_ff[2]; // [R11]
   assign LOCKOUT_INDICATOR_O = state_flags_ff[2]; // [R11]

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   a_flags_onehot: assert property (@(posedge CLK_I) disable iff (RESET_I) // [R5]
      $onehot(flags_ff) && flags_ff[shot_ff])
      else $error("shot flags do not match shot");

   a_edge_start: assert property (@(posedge CLK_I) disable iff (RESET_I) // [R7]
      START_OPEN_INTERVAL_O |-> !$past(ri_prev_ff) && ri_prev_ff)
      else $error("start without initiate edge");

   a_supv_start: assert property (@(posedge CLK_I) disable iff (RESET_I) // [R8]
      ri_rise && supv && !dtl_eff && !timing_ff && shot_ff < last_shot |=> START_OPEN_INTERVAL_O)
      else $error("supervised edge did not start interval");

   a_unsup_lock: assert property (@(posedge CLK_I) disable iff (RESET_I) // [R9]
      ri_rise && !supv |=> LOCKOUT_FLAG_O && !START_OPEN_INTERVAL_O)
      else $error("unsupervised edge did not lock out");

   a_dtl_lockout: assert property (@(posedge CLK_I) disable iff (RESET_I) // [R11]
      DRIVE_TO_LOCKOUT_COND_I |=> LOCKOUT_FLAG_O && LOCKOUT_INDICATOR_O)
      else $error("drive to lockout ignored");

   a_dtl_stretch: assert property (@(posedge CLK_I) disable iff (RESET_I) // [R12]
      $fell(DRIVE_TO_LOCKOUT_COND_I) |-> drop_cnt_ff == DROPOUT_TICKS && dtl_eff)
      else $error("dropout stretch not reloaded");

   a_reset_clear: assert property (@(posedge CLK_I) disable iff (RESET_I) // [R3]
      RESET_STATE_O && !$past(RESET_STATE_O) |-> SHOT_O == SHOT_ZERO)
      else $error("shot not cleared on reset state");

   a_auto_sat: assert property (@(posedge CLK_I) disable iff (RESET_I) // [R2]
      OPEN_INTERVAL_EXPIRED_I && !SEQUENCE_COORDINATION_COND_I && !DRIVE_TO_LAST_SHOT_COND_I
      && shot_ff == last_shot && !RESET_TIMER_DONE_I |=> shot_ff == $past(shot_ff))
      else $error("shot advanced past last shot");

   a_dls_load: assert property (@(posedge CLK_I) disable iff (RESET_I) // [R13]
      DRIVE_TO_LAST_SHOT_COND_I && shot_ff < last_shot && !RESET_TIMER_DONE_I |=> shot_ff == $past(last_shot))
      else $error("last shot not loaded");

   a_cycle_flag: assert property (@(posedge CLK_I) disable iff (RESET_I) // [R15]
      $onehot({RESET_STATE_O, RECLOSE_CYCLE_FLAG_O, LOCKOUT_FLAG_O}))
      else $error("state flags not exclusive");

endmodule // rsl_core

// [bench/rsl_far.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// Far side: the breaker that trip edges open, plus the interval timer
module rsl_far #(
   parameter int DLY = 20 // Open interval length in cycles
) (
   input wire logic clk_i,
   input wire logic trip_i,
   input wire logic start_i,
   input wire logic close_i,
   output logic brk_closed_o,
   output logic expired_o
);
   int cnt = 0; // Interval countdown, 0 = idle
   logic trip_q = 1'b0; // Previous trip level
   logic brk_q = 1'b1; // Breaker closed at start
   logic exp_q = 1'b0; // Expiry pulse
   assign brk_closed_o = brk_q;
   assign expired_o = exp_q;
   // A trip edge opens the breaker; reclosure or a manual close closes it
   always @(posedge clk_i) begin
      trip_q <= trip_i;
      exp_q <= 1'b0;
      if (trip_i && !trip_q) begin
         brk_q <= 1'b0;
      end
      if (close_i) begin
         brk_q <= 1'b1;
      end
      if (start_i) begin
         cnt <= DLY;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         // Single-cycle pulse; the breaker recloses on the same edge
         cnt <= 0;
         exp_q <= 1'b1;
         brk_q <= 1'b1;
      end
   end
endmodule // rsl_far

// [bench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
   import rsl_pkg::*;
   localparam int TCK = 4; // Short tick keeps the dropout at 4000 cycles
   logic CLK_I = 1'b0;
   logic RESET_I = 1'b1;
   logic [OI_W-1:0] oi [4]; // Interval settings
   logic ri_sup = 1'b1, sup_def = 1'b1, dtl = 1'b0, dls = 1'b0, seq = 1'b0, trip = 1'b0, rdone = 1'b0;
   logic [SHOT_W-1:0] shot, last;
   logic [4:0] flg;
   logic [OI_W-1:0] sel;
   logic start, timing, st_rst, st_cyc, st_lo, lo_ind, brk, expd;
   int n_errors = 0, n_tests = 0, m_shot = 0, m_st = 0, seed = 57, i, k;
   ////////////////////////////////////////////////////////////
   always #5 CLK_I = ~CLK_I;
   rsl_far #(.DLY(20)) far_u (.clk_i(CLK_I), .trip_i(trip), .start_i(start), .close_i(rdone),
      .brk_closed_o(brk), .expired_o(expd));
   rsl_core #(.TICK_CYCLES(TCK)) dut_u (.CLK_I(CLK_I), .RESET_I(RESET_I),
      .OPEN_INTERVAL_ONE_I(oi[0]), .OPEN_INTERVAL_TWO_I(oi[1]), .OPEN_INTERVAL_THREE_I(oi[2]),
      .OPEN_INTERVAL_FOUR_I(oi[3]), .RECLOSE_INITIATE_COND_I(trip), .RECLOSE_INITIATE_SUPERVISION_I(ri_sup),
      .SUPERVISION_DEFAULT_I(sup_def), .DRIVE_TO_LOCKOUT_COND_I(dtl), .DRIVE_TO_LAST_SHOT_COND_I(dls),
      .SEQUENCE_COORDINATION_COND_I(seq), .BREAKER_CLOSED_STATUS_I(brk), .OPEN_INTERVAL_EXPIRED_I(expd),
      .RESET_TIMER_DONE_I(rdone), .SHOT_O(shot), .LAST_SHOT_O(last), .SHOT_FLAG_ZERO_O(flg[0]),
      .SHOT_FLAG_ONE_O(flg[1]), .SHOT_FLAG_TWO_O(flg[2]), .SHOT_FLAG_THREE_O(flg[3]), .SHOT_FLAG_FOUR_O(flg[4]),
      .OPEN_INTERVAL_SEL_O(sel), .START_OPEN_INTERVAL_O(start), .OPEN_INTERVAL_TIMING_O(timing),
      .RESET_STATE_O(st_rst), .RECLOSE_CYCLE_FLAG_O(st_cyc), .LOCKOUT_FLAG_O(st_lo), .LOCKOUT_INDICATOR_O(lo_ind));
   ////////////////////////////////////////////////////////////
   // Reference: nonzero intervals ahead of the first zero
   function automatic int m_last;
      int n;
      n = 0;
      while (n < 4 && oi[n] != OI_NONE) n++;
      return n;
   endfunction
   // Report, verdict and end of run
   task stop_test;
      $display("counts: %0d checks, %0d mismatches", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // Drives follow cyc at a rising edge; look samples after the next edge
   task cyc(input int n);
      repeat (n) @(posedge CLK_I);
   endtask
   task look;
      @(posedge CLK_I);
      @(negedge CLK_I);
   endtask
   // Shot, flags, interval select, state and indicator against the model
   task chk_state;
      check("shot", shot, m_shot);
      check("flags", flg, 5'h1 << m_shot);
      check("sel", sel, m_shot < 4 ? oi[m_shot] : OI_NONE);
      check("state", {st_lo, st_cyc, st_rst}, 3'h1 << m_st);
      check("indicator", lo_ind, m_st == 2);
   endtask
   // Bounded wait: a hang counts as a mismatch
   task wait_shot(input int v);
      for (k = 0; k < 100 && shot !== v; k++) @(negedge CLK_I);
      if (shot !== v) begin
         check("shot wait", shot, v[15:0]);
         stop_test;
      end
   endtask
   // Reset timer done plus manual close; then let the far side go quiet
   task to_reset;
      cyc(1);
      trip <= 1'b0;
      rdone <= 1'b1;
      look;
      m_st = 0;
      m_shot = 0;
      chk_state;
      cyc(1);
      rdone <= 1'b0;
      cyc(24);
   endtask
   task hard_reset;
      cyc(1);
      RESET_I <= 1'b1;
      cyc(3);
      RESET_I <= 1'b0;
      m_shot = 0;
      m_st = 0;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      for (k = 0; k < 4; k++) oi[k] = OI_NONE;
      repeat (6) @(posedge CLK_I);
      RESET_I <= 1'b0;
      @(negedge CLK_I);
      chk_state;
      // Random settings: last shot and interval select
      for (i = 0; i < 8; i++) begin
         cyc(1);
         for (k = 0; k < 4; k++) oi[k] <= ($random(seed) % 3 == 0) ? OI_NONE : 16'($random(seed) & 32'h7FFF) + 16'h1;
         look;
         look;
         check("last", last, m_last());
         chk_state;
      end
      $display("test last_shot done");
      // Full sequence to last shot then lockout
      cyc(1);
      oi[0] <= 16'h0005;
      oi[1] <= 16'h0007;
      oi[2] <= OI_NONE;
      oi[3] <= 16'h0009;
      look;
      look;
      check("last", last, 3'h2);
      for (i = 1; i <= 2; i++) begin
         cyc(1);
         trip <= 1'b1;
         look;
         m_st = 1;
         check("start", start, 1'b1);
         check("timing", timing, 1'b1);
         chk_state;
         look;
         check("start", start, 1'b0);
         cyc(1);
         trip <= 1'b0;
         wait_shot(i);
         m_shot = i;
         chk_state;
         check("timing", timing, 1'b0);
      end
      cyc(1);
      trip <= 1'b1;
      look;
      m_st = 2;
      chk_state;
      check("start", start, 1'b0);
      to_reset;
      $display("test sequence done");
      // Trip while open mid-interval
      cyc(1);
      trip <= 1'b1;
      look;
      m_st = 1;
      check("start", start, 1'b1);
      cyc(1);
      trip <= 1'b0;
      cyc(6);
      trip <= 1'b1;
      look;
      m_st = 2;
      chk_state;
      check("timing", timing, 1'b0);
      // Late expiry lands while the shot sits at last shot
      cyc(1);
      trip <= 1'b0;
      dls <= 1'b1;
      cyc(1);
      dls <= 1'b0;
      cyc(20);
      look;
      m_shot = 2;
      chk_state;
      to_reset;
      $display("test flashover done");
      // External supervision low then high
      for (i = 0; i < 2; i++) begin
         cyc(1);
         sup_def <= 1'b0;
         ri_sup <= i[0];
         trip <= 1'b1;
         look;
         m_st = i ? 1 : 2;
         check("start", start, i[0]);
         chk_state;
         to_reset;
      end
      $display("test supervision done");
      // Coordination steps past last shot, saturating at four
      cyc(1);
      sup_def <= 1'b1;
      seq <= 1'b1;
      for (i = 0; i < 5; i++) begin
         look;
         m_shot = m_shot < 4 ? m_shot + 1 : 4;
         chk_state;
      end
      cyc(1);
      seq <= 1'b0;
      hard_reset;
      $display("test coordination done");
      // Drive to last shot loads only when below
      cyc(1);
      dls <= 1'b1;
      look;
      m_shot = 2;
      chk_state;
      cyc(1);
      seq <= 1'b1;
      look;
      m_shot = 3;
      chk_state;
      cyc(1);
      seq <= 1'b0;
      look;
      m_shot = 4;
      chk_state;
      cyc(1);
      dls <= 1'b0;
      hard_reset;
      $display("test last_shot_drive done");
      // Drive to lockout, then measure the dropout stretch
      cyc(1);
      dtl <= 1'b1;
      look;
      m_st = 2;
      chk_state;
      cyc(1);
      dtl <= 1'b0;
      rdone <= 1'b1;
      for (k = 0; k < 6000 && st_rst !== 1'b1; k++) @(negedge CLK_I);
      check("dropout", k >= 3990 && k <= 4010, 1'b1);
      $display("test dropout done");
      stop_test;
   end
endmodule // tb_top
